// ===== core/usr_core.sv
// Serial timing core: sync edges, host SPI shifting, async recovery
`timescale 1ns/1ps
module usr_core (
    input  wire logic           core_clk,     // Peripheral clock
    input  wire logic           rst_n,        // Async reset, active low
    input  wire usr_pkg::usr_cfg_t cfg,       // Configuration
    input  wire logic           baud_tick,    // Baud generator tick
    input  wire logic [7:0]     tx_data,      // Transmit byte
    input  wire logic           tx_valid,     // Transmit byte offered
    output logic                tx_ready,     // Shift register free
    output logic                tx_done,      // Frame shifted out pulse
    input  wire logic           rxd_pin,      // Receive data pin
    output logic                txd_out,      // Transmit data pin
    input  wire logic           xck_in,       // Serial clock pin input
    output logic                xck_out,      // Serial clock pin output
    output logic                xck_oe_n,     // Serial clock enable, low
    output usr_pkg::usr_rx_t    rx_word,      // Received frame
    output logic                rx_valid      // Frame received pulse
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rxd_sync;
    logic [1:0] xck_sync;
    logic       xck_prev;
    logic       rxd_s;
    logic       xck_s;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_sync <= 2'h3;
            xck_sync <= 2'h0;
            xck_prev <= 1'b0;
        end else begin
            rxd_sync <= {rxd_sync[0], rxd_pin};
            xck_sync <= {xck_sync[0], xck_in};
            xck_prev <= xck_sync[1];
        end
    end
    assign rxd_s = rxd_sync[1];
    assign xck_s = xck_sync[1];

    // ------------------------------------------------------------
    // Mode decode and edge selection
    // ------------------------------------------------------------
    wire is_spi    = (cfg.mode == usr_pkg::USR_MODE_SPI);
    wire is_client = (cfg.mode == usr_pkg::USR_MODE_SYNC_C);
    wire is_sync   = (cfg.mode != usr_pkg::USR_MODE_ASYNC);
    wire is_host   = is_sync && !is_client;
    wire dbl       = (cfg.receive_mode_field == usr_pkg::RXM_DOUBLE)
                     && !is_spi;
    assign xck_oe_n = !is_host;

    // Host toggles its clock on each baud tick while a frame shifts, then stops once back low
    logic       xck_host;
    logic       host_rise;
    logic       host_fall;
    assign host_rise = is_host && baud_tick && !xck_host;
    assign host_fall = is_host && baud_tick && xck_host;
    // Client edges come only from the pin, no baud tick
    wire cl_rise = is_client && xck_s && !xck_prev;
    wire cl_fall = is_client && !xck_s && xck_prev;
    wire e_rise  = host_rise || cl_rise;
    wire e_fall  = host_fall || cl_fall;
    // In host SPI mode only, phase swaps which edge of the pair shifts
    // Host edges are taken before pin inversion, client edges at the pin
    wire shift_on_rise = is_client ? !cfg.pin_invert_enable
                         : (cfg.clock_phase_select || !is_spi);
    wire shift_edge  = shift_on_rise ? e_rise : e_fall;
    wire sample_edge = shift_on_rise ? e_fall : e_rise;
    assign xck_out = xck_host ^ cfg.pin_invert_enable;

    // ------------------------------------------------------------
    // Synchronous transmit / receive shifter
    // ------------------------------------------------------------
    logic [7:0] sh_tx;
    logic [7:0] sh_rx;
    logic [3:0] sh_cnt;
    logic       sh_busy;
    logic       sh_first;
    logic       sync_done;
    wire [3:0]  sh_last = is_spi ? usr_pkg::SPI_BITS
                                 : cfg.char_bits;
    wire        sh_lsb  = !(is_spi && cfg.bit_order_select);
    wire        sh_out  = sh_lsb ? sh_tx[0] : sh_tx[7];
    wire        sh_load = !sh_busy && tx_valid && is_sync;
    wire [7:0]  sh_rx_n = sh_lsb ? {rxd_s, sh_rx[7:1]}
                                 : {sh_rx[6:0], rxd_s};
    wire        sh_step = sh_busy && shift_edge && !sh_first;
    wire        sh_end  = sh_busy && sample_edge
                          && (sh_cnt == sh_last - 4'h1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xck_host <= 1'b0;
            sh_tx    <= usr_pkg::DATA_RST;
            sh_rx    <= usr_pkg::DATA_RST;
            sh_cnt   <= 4'h0;
            sh_busy  <= 1'b0;
            sh_first <= 1'b0;
        end else begin
            if (is_host && baud_tick && (sh_busy || xck_host))
                xck_host <= !xck_host;
            if (sh_load) begin
                sh_tx    <= tx_data;
                sh_cnt   <= 4'h0;
                sh_busy  <= 1'b1;
                sh_first <= shift_on_rise
                            ^ (is_client && cfg.pin_invert_enable);
            end else begin
                if (shift_edge && sh_busy)
                    sh_first <= 1'b0;
                if (sh_step)
                    sh_tx <= sh_lsb ? {1'b0, sh_tx[7:1]}
                                    : {sh_tx[6:0], 1'b0};
                if (sh_busy && sample_edge) begin
                    sh_rx  <= sh_rx_n;
                    sh_cnt <= sh_cnt + 4'h1;
                end
                if (sh_end)
                    sh_busy <= 1'b0;
            end
        end
    end
    assign sync_done = sh_end;

    // ------------------------------------------------------------
    // Asynchronous clock and data recovery
    // ------------------------------------------------------------
    usr_pkg::usr_rx_state_t rx_state;
    logic [4:0] os_cnt;
    logic [3:0] bit_cnt;
    logic [2:0] votes;
    logic [8:0] rx_sh;
    logic       rx_par;
    wire  [4:0] ovs    = dbl ? usr_pkg::OVS_DOUBLE
                             : usr_pkg::OVS_NORMAL;
    wire  [4:0] vfirst = dbl ? usr_pkg::VOTE_DOUBLE
                             : usr_pkg::VOTE_NORMAL;
    wire        in_vote = (os_cnt >= vfirst)
                          && (os_cnt <= vfirst + 5'h2);
    wire        vote_end = (os_cnt == vfirst + 5'h2);
    wire  [2:0] votes_n = {votes[1:0], rxd_s};
    wire        maj     = (votes_n[0] & votes_n[1])
                          | (votes_n[1] & votes_n[2])
                          | (votes_n[0] & votes_n[2]);
    wire  [3:0] nbits   = cfg.char_bits + {3'h0, cfg.parity_enable};
    wire        a_tick  = baud_tick && !is_sync;
    wire        stop_low;
    wire        async_done;
    logic       stop_seen;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state  <= usr_pkg::USR_RX_IDLE;
            os_cnt    <= 5'h0;
            bit_cnt   <= 4'h0;
            votes     <= 3'h7;
            rx_sh     <= 9'h000;
            stop_seen <= 1'b0;
        end else begin
            stop_seen <= 1'b0;
            if (a_tick) begin
                if (in_vote)
                    votes <= votes_n;
                unique case (rx_state)
                    usr_pkg::USR_RX_IDLE: begin
                        if (!rxd_s) begin
                            os_cnt   <= 5'h2;
                            rx_state <= usr_pkg::USR_RX_START;
                        end
                    end
                    usr_pkg::USR_RX_START: begin
                        os_cnt <= os_cnt + 5'h1;
                        if (vote_end) begin
                            if (maj)
                                rx_state <= usr_pkg::USR_RX_IDLE;
                            else begin
                                // Counter restarts at bit centre
                                os_cnt   <= vfirst + 5'h3 - ovs;
                                bit_cnt  <= 4'h0;
                                rx_state <= usr_pkg::USR_RX_DATA;
                            end
                        end
                    end
                    usr_pkg::USR_RX_DATA: begin
                        os_cnt <= os_cnt + 5'h1;
                        if (vote_end) begin
                            os_cnt  <= vfirst + 5'h3 - ovs;
                            rx_sh   <= {maj, rx_sh[8:1]};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == nbits - 4'h1)
                                rx_state <= usr_pkg::USR_RX_STOP;
                        end
                    end
                    usr_pkg::USR_RX_STOP: begin
                        os_cnt <= os_cnt + 5'h1;
                        if (vote_end) begin
                            stop_seen <= 1'b1;
                            rx_state  <= usr_pkg::USR_RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end
    assign stop_low   = !maj;
    assign async_done = a_tick && vote_end
                        && (rx_state == usr_pkg::USR_RX_STOP);

    // ------------------------------------------------------------
    // Result registers and handshake
    // ------------------------------------------------------------
    wire [8:0] a_align = rx_sh >> (4'h9 - nbits);
    wire [8:0] a_data  = cfg.parity_enable
                         ? (a_align & ~(9'h001 << cfg.char_bits))
                         : a_align;
    wire       a_par   = ^a_align;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_word  <= '0;
            rx_valid <= 1'b0;
            tx_done  <= 1'b0;
            txd_out  <= 1'b1;
            rx_par   <= 1'b0;
        end else begin
            rx_valid <= async_done || (sync_done && is_sync);
            tx_done  <= sync_done;
            rx_par   <= a_par;
            txd_out  <= sh_busy ? sh_out : 1'b1;
            if (async_done) begin
                rx_word.data         <= a_data;
                rx_word.frame_error  <= stop_low;
                rx_word.parity_error <= cfg.parity_enable && a_par;
            end else if (sync_done) begin
                rx_word.data         <= {1'b0, sh_rx_n};
                rx_word.frame_error  <= 1'b0;
                rx_word.parity_error <= 1'b0;
            end
        end
    end
    assign tx_ready = !sh_busy && is_sync;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_spi_err_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        rx_valid && $past(is_spi) |-> !rx_word.frame_error
        && !rx_word.parity_error)
        else $error("SPI error flag set");
    a_oe_role: assert property (@(posedge core_clk) disable iff (!rst_n)
        xck_oe_n == is_client || !is_sync)
        else $error("clock pin direction wrong");
    a_start_reject: assert property (@(posedge core_clk) disable iff (!rst_n)
        a_tick && rx_state == usr_pkg::USR_RX_START && vote_end && maj
        |=> rx_state == usr_pkg::USR_RX_IDLE)
        else $error("start bit not rejected");
    a_start_align: assert property (@(posedge core_clk) disable iff (!rst_n)
        a_tick && rx_state == usr_pkg::USR_RX_START && vote_end && !maj
        |=> os_cnt == vfirst + 5'h3 - ovs)
        else $error("counter not aligned");
    a_stop_ferr: assert property (@(posedge core_clk) disable iff (!rst_n)
        async_done |=> rx_valid && rx_word.frame_error == $past(stop_low))
        else $error("frame error mismatch");
    a_idle_after: assert property (@(posedge core_clk) disable iff (!rst_n)
        async_done |=> rx_state == usr_pkg::USR_RX_IDLE)
        else $error("not idle after stop");
    a_client_clk: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_client && !(xck_sync[1] ^ xck_prev) |-> !e_rise && !e_fall)
        else $error("client edge without pin edge");
    a_spi_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_spi && sync_done |-> sh_cnt == 4'h7)
        else $error("SPI frame not eight bits");
    a_edge_split: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(shift_edge && sample_edge))
        else $error("shift and sample coincide");
    c_spi_frame:  cover property (@(posedge core_clk) is_spi && sync_done);
    c_async_ok:   cover property (@(posedge core_clk)
        async_done && !stop_low);
    c_async_ferr: cover property (@(posedge core_clk)
        async_done && stop_low);
    c_dbl_start:  cover property (@(posedge core_clk)
        dbl && rx_state == usr_pkg::USR_RX_DATA);
endmodule

// ===== core/usr_pkg.sv
// Package with constants and carrier types of the serial timing core
package usr_pkg;
    localparam int          CLK_HZ        = 40000000;
    localparam logic [4:0]  OVS_NORMAL    = 5'h10;
    localparam logic [4:0]  OVS_DOUBLE    = 5'h08;
    localparam logic [4:0]  VOTE_NORMAL   = 5'h08;
    localparam logic [4:0]  VOTE_DOUBLE   = 5'h04;
    localparam logic [3:0]  SPI_BITS      = 4'h8;
    localparam logic [1:0]  RXM_NORMAL    = 2'h0;
    localparam logic [1:0]  RXM_DOUBLE    = 2'h1;
    localparam logic [7:0]  DATA_RST      = 8'h00;

    typedef enum logic [1:0] {
        USR_MODE_ASYNC   = 2'h0,
        USR_MODE_SYNC_H  = 2'h1,
        USR_MODE_SYNC_C  = 2'h2,
        USR_MODE_SPI     = 2'h3
    } usr_mode_t;

    typedef enum logic [1:0] {
        USR_RX_IDLE  = 2'h0,
        USR_RX_START = 2'h1,
        USR_RX_DATA  = 2'h2,
        USR_RX_STOP  = 2'h3
    } usr_rx_state_t;

    typedef struct packed {
        usr_mode_t  mode;
        logic [1:0] receive_mode_field;
        logic       pin_invert_enable;
        logic       clock_phase_select;
        logic       bit_order_select;
        logic       parity_enable;
        logic [3:0] char_bits;
    } usr_cfg_t;

    typedef struct packed {
        logic [8:0] data;
        logic       frame_error;
        logic       parity_error;
    } usr_rx_t;
endpackage

// ===== dv/usr_core_tb_top.sv
// Self-checking bench of the serial timing core
`timescale 1ns/1ps
module usr_core_tb_top;
    logic              core_clk = 1'b0;
    logic              rst_n = 1'b0;
    usr_pkg::usr_cfg_t cfg;
    logic              baud_tick = 1'b0;
    logic [1:0]        tick_cnt = 2'h0;
    logic [7:0]        tx_data = 8'h00;
    logic              tx_valid = 1'b0;
    logic              tx_ready, tx_done, txd_out, xck_out, xck_oe_n;
    logic              rx_valid, rxd, miso;
    logic              tb_rxd = 1'b1;
    logic              clr = 1'b0;
    logic [7:0]        resp = 8'h00;
    logic [7:0]        got;
    logic [3:0]        n_got;
    usr_pkg::usr_rx_t  rx_word;
    usr_pkg::usr_rx_t  rxq[$];
    int                n_mismatch = 0;
    int                samples_checked = 0;
    int                cyc = 0;
    int                n_done = 0;
    int                n0;

    //--------------------------------------------------------------
    // Clock, ticks and monitors
    //--------------------------------------------------------------
    always #12.5 core_clk = ~core_clk;
    assign rxd = (cfg.mode == usr_pkg::USR_MODE_SPI) ? miso : tb_rxd;
    always @(posedge core_clk) begin
        tick_cnt  <= tick_cnt + 2'h1;
        baud_tick <= (tick_cnt == 2'h3);
        cyc       <= cyc + 1;
        if (rx_valid === 1'b1) rxq.push_back(rx_word);
        if (tx_done === 1'b1) n_done <= n_done + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            complete_run();
        end
    end

    usr_core dut (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg),
        .baud_tick(baud_tick), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_done(tx_done), .rxd_pin(rxd),
        .txd_out(txd_out), .xck_in(1'b0), .xck_out(xck_out),
        .xck_oe_n(xck_oe_n), .rx_word(rx_word), .rx_valid(rx_valid));
    usr_spi_client partner (.core_clk(core_clk), .clr(clr), .sck(xck_out),
        .mosi(txd_out), .phase(cfg.clock_phase_select),
        .sample_rise(cfg.pin_invert_enable ~^ cfg.clock_phase_select),
        .msb_first(cfg.bit_order_select), .resp(resp), .miso(miso),
        .got(got), .n_got(n_got));

    //--------------------------------------------------------------
    // Shared tasks
    //--------------------------------------------------------------
    task complete_run;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task send_frame(input logic [7:0] d, input logic stop_v, input int os);
        int s;
        s = (cfg.receive_mode_field == usr_pkg::RXM_DOUBLE) ? 8 : 16;
        tb_rxd <= 1'b0;
        cycles(s * 4);
        for (int i = 0; i < 8; i++) begin
            tb_rxd <= d[i];
            cycles(s * 4);
        end
        tb_rxd <= stop_v;
        cycles(os * 4);
        if (!stop_v) tb_rxd <= 1'b1;
    endtask
    task expect_rx(input logic [7:0] d, input logic fe);
        usr_pkg::usr_rx_t w;
        for (int i = 0; i < 400 && rxq.size() == 0; i++) cycles(1);
        if (rxq.size() == 0) begin
            chk(1'b0, "no frame received");
        end else begin
            w = rxq.pop_front();
            chk(w.data[7:0] === d && w.frame_error === fe
                && w.parity_error === 1'b0, "received word wrong");
        end
    endtask
    task offer(input logic [7:0] d);
        n0 = n_done;
        tx_data  <= d;
        tx_valid <= 1'b1;
        for (int i = 0; i < 50 && tx_ready !== 1'b1; i++) @(negedge core_clk);
        @(posedge core_clk);
        tx_valid <= 1'b0;
    endtask

    //--------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------
    task sc_async;
        cycles(20);
        send_frame(8'hA5, 1'b1, 16);
        expect_rx(8'hA5, 1'b0);
        send_frame(8'h3C, 1'b0, 16);
        expect_rx(8'h3C, 1'b1);
    endtask
    task sc_reject;
        cycles(20);
        tb_rxd <= 1'b0;
        cycles(12);
        tb_rxd <= 1'b1;
        cycles(160);
        chk(rxq.size() == 0, "short start taken");
    endtask
    task sc_b2b;
        cycles(20);
        send_frame(8'h81, 1'b1, 12);
        send_frame(8'h7E, 1'b1, 16);
        expect_rx(8'h81, 1'b0);
        expect_rx(8'h7E, 1'b0);
    endtask
    task sc_double;
        cfg.receive_mode_field <= usr_pkg::RXM_DOUBLE;
        cycles(20);
        send_frame(8'h69, 1'b1, 9);
        send_frame(8'hC3, 1'b1, 8);
        expect_rx(8'h69, 1'b0);
        expect_rx(8'hC3, 1'b0);
    endtask
    task sc_spi;
        for (int k = 0; k < 8; k++) begin
            cfg.mode <= usr_pkg::USR_MODE_SPI;
            cfg.pin_invert_enable  <= k[0];
            cfg.clock_phase_select <= k[1];
            cfg.bit_order_select   <= k[2];
            resp <= 8'h4E ^ k[7:0];
            clr  <= 1'b1;
            cycles(4);
            clr <= 1'b0;
            cycles(8);
            chk(xck_out === k[0] && xck_oe_n === 1'b0, "idle clock");
            offer(8'h1D ^ k[7:0]);
            for (int i = 0; i < 400 && n_done == n0; i++) cycles(1);
            cycles(4);
            chk(got === (8'h1D ^ k[7:0]) && n_got === 4'h8, "mosi");
            expect_rx(8'h4E ^ k[7:0], 1'b0);
            chk(n_done == n0 + 1, "done count");
        end
    endtask
    task sc_roles;
        cfg.mode <= usr_pkg::USR_MODE_SYNC_H;
        cycles(4);
        chk(xck_oe_n === 1'b0, "host clock not driven");
        cfg.mode <= usr_pkg::USR_MODE_SYNC_C;
        cycles(4);
        chk(xck_oe_n === 1'b1, "client clock driven");
        offer(8'h55);
        cycles(200);
        chk(n_done == n0, "client ran on baud ticks");
    endtask

    //--------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------
    initial begin
        cfg = '{mode: usr_pkg::USR_MODE_ASYNC,
                receive_mode_field: usr_pkg::RXM_NORMAL,
                pin_invert_enable: 1'b0, clock_phase_select: 1'b0,
                bit_order_select: 1'b0, parity_enable: 1'b0,
                char_bits: 4'h8};
        cycles(2);
        rst_n <= 1'b1;
        cycles(4);
        sc_async();
        sc_reject();
        sc_b2b();
        sc_double();
        sc_spi();
        sc_roles();
        complete_run();
    end
endmodule

// ===== dv/usr_spi_client.sv
// SPI client model facing the host SPI side of the serial timing core
`timescale 1ns/1ps
module usr_spi_client (
    input  wire logic       core_clk,    // Peripheral clock
    input  wire logic       clr,         // Frame restart
    input  wire logic       sck,         // Shared serial clock
    input  wire logic       mosi,        // Host out
    input  wire logic       sample_rise, // Sample on rising edge
    input  wire logic       phase,       // Clock phase in use
    input  wire logic       msb_first,   // Bit order in use
    input  wire logic [7:0] resp,        // Byte sent back
    output logic            miso,        // Host in
    output logic [7:0]      got,         // Byte captured
    output logic [3:0]      n_got        // Sample edges seen
);
    logic       sck_q;
    logic [3:0] n_sh;
    logic [3:0] idx;
    logic       rise;
    logic       fall;
    logic       smp;
    logic       shf;

    assign rise = sck & ~sck_q;
    assign fall = ~sck & sck_q;
    assign smp  = sample_rise ? rise : fall;
    assign shf  = sample_rise ? fall : rise;
    // Next bit goes out on the shift edge itself, ahead of the pin sync
    assign idx  = n_sh + {3'h0, shf} - {3'h0, phase};

    always_ff @(posedge core_clk) begin
        sck_q <= sck;
        if (clr) begin
            n_sh  <= 4'h0;
            n_got <= 4'h0;
            got   <= 8'h00;
        end else begin
            if (smp) begin
                got   <= msb_first ? {got[6:0], mosi} : {mosi, got[7:1]};
                n_got <= n_got + 4'h1;
            end
            if (shf) begin
                n_sh <= n_sh + 4'h1;
            end
        end
        // Outside the frame the line toggles every cycle
        if (idx < 4'h8) begin
            miso <= msb_first ? resp[3'h7 - idx[2:0]] : resp[idx[2:0]];
        end else begin
            miso <= ~miso;
        end
    end
endmodule
